// ===== verilog/smr_map.vh
// Constants for the serial memory readout host controller.
// Assumes the device is already in its low-level programming mode.
//
// Contract
// - Code 0000 sends instruction, 0001 shifts readout.
// - Code read copies working regs to readout.
// - Reset program counter after each output group.
// - Repeat output and counter reset until done.
// - Seven config registers read one each pass.
// - Config page 0xF8, read pointer starts zero.
// - Two jumps and no-op leave reset vector.
// - Load page via reg 0, clear both pointers.
// - Table read, two no-ops, copy, no-op.
// - Repeat config read, output, counter reset.
// - Move ID to readout, then shift out.
// - ID 0xBB means executive is resident.
// - Other ID means executive must be loaded.
// - Table reads pack four code words first.
`ifndef SMR_MAP_VH
`define SMR_MAP_VH
// -----------------------------------------------------------------
// Control codes and instruction words
// -----------------------------------------------------------------
`define SMR_CODE_EXEC    4'h0
`define SMR_CODE_REGISTER_SHIFT_OUT_COMMAND  4'h1
`define SMR_OP_NOP       24'h000000
`define SMR_OP_JUMP100   24'h040100
`define SMR_OP_W0_RDOUT  24'h883C20
`define SMR_OP_PAGE_W0   24'h200F80
`define SMR_OP_W0_TBLPG  24'h880190
`define SMR_OP_CLR_RDPTR 24'hEB0300
`define SMR_OP_CLR_WRPTR 24'hEB0380
`define SMR_OP_TABLE_READ_LOW    24'hBA0BB6
`define SMR_OP_ID_PAGE   24'h200800
`define SMR_OP_ID_ADDR   24'h205BE0
`define SMR_OP_ID_DEST   24'h207841
`define SMR_OP_ID_TBLRD  24'hBA0890
`define SMR_RDOUT_ADDR   16'h0784
`define SMR_ID_ADDR      24'h8005BE
`define SMR_ID_RESIDENT  8'hBB
`define SMR_CFG_WORDS    3'h7
`define SMR_RDOUT_BITS   5'h10
// -----------------------------------------------------------------
// Timing: link clock half period in core cycles
// -----------------------------------------------------------------
`define SMR_HALF_NS      40
`define SMR_CLK_NS       10
`define SMR_HALF_CYC     ((`SMR_HALF_NS + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
`endif

// ===== verilog/smr_shifter.v
// Bit-level engine: sends a 4-bit code plus 24-bit word, or a code then reads 16 bits.
// Assumes one core clock and a device sampling data on the rising link clock.
`include "smr_map.vh"
module smr_shifter #(
    parameter HALF = `SMR_HALF_CYC      // Core cycles per link half period
) (
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rstn,
    // Command
    input  wire        i_start,         // One-cycle start pulse
    input  wire [3:0]  i_code,          // Control code
    input  wire [23:0] i_word,          // Instruction word
    output reg         o_done,          // One-cycle completion pulse
    output reg  [15:0] o_rdata,         // Shifted-in readout value
    // Pins
    output reg         o_pgc,           // Link clock
    output reg         o_pgd,           // Data out
    output reg         o_pgd_oe,        // Data drive enable
    input  wire        i_pgd            // Data in (unsynchronised)
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    reg [7:0]  div;                     // Half-period divider
    reg [5:0]  nbit;                    // Bits left
    reg [27:0] sh;                      // Outgoing shift register
    reg        busy;                    // Transfer in progress
    reg        rd;                      // Now in read phase
    reg        is_out;                  // Current command is register-out
    reg        pgd_s1;                  // Synchroniser stage one
    reg        pgd_s2;                  // Synchroniser stage two
    wire       tick = (div == 8'h00);   // Half-period enable pulse

    // Two flops on the incoming data pin
    always @(posedge i_ref_clk) begin
        pgd_s1 <= i_pgd;
        pgd_s2 <= pgd_s1;
    end

    // Shifter: data changes on falling link edge, device samples on rising
    always @(posedge i_ref_clk) begin
        o_done <= 1'b0;
        if (!i_rstn) begin
            div      <= 8'h00;
            nbit     <= 6'h00;
            sh       <= 28'h0000000;
            busy     <= 1'b0;
            rd       <= 1'b0;
            is_out   <= 1'b0;
            o_pgc    <= 1'b0;
            o_pgd    <= 1'b0;
            o_pgd_oe <= 1'b0;
            o_rdata  <= 16'h0000;
        end else if (!busy) begin
            if (i_start) begin
                // Code is sent LSB first, then the word LSB first
                sh     <= {i_word, i_code};
                nbit   <= (i_code == `SMR_CODE_REGISTER_SHIFT_OUT_COMMAND) ? 6'd4 : 6'd28;
                is_out <= (i_code == `SMR_CODE_REGISTER_SHIFT_OUT_COMMAND);
                rd     <= 1'b0;
                busy   <= 1'b1;
                o_pgd_oe <= 1'b1;
                o_pgd  <= i_code[0];
                div    <= HALF[7:0] - 8'h01;
            end
        end else if (tick) begin
            div   <= HALF[7:0] - 8'h01;
            o_pgc <= ~o_pgc;
            if (o_pgc) begin
                // Falling edge: move to next bit
                if (nbit == 6'd1) begin
                    if (is_out && !rd) begin
                        // Release the line and collect the readout
                        rd       <= 1'b1;
                        o_pgd_oe <= 1'b0;
                        nbit <= {1'b0, `SMR_RDOUT_BITS};
                    end else begin
                        busy     <= 1'b0;
                        o_done   <= 1'b1;
                        o_pgd_oe <= 1'b0;
                    end
                end else begin
                    nbit <= nbit - 6'd1;
                    sh   <= {1'b0, sh[27:1]};
                    o_pgd <= sh[1];
                end
            end else if (rd) begin
                // Rising edge: capture readout, MSB first
                o_rdata <= {o_rdata[14:0], pgd_s2};
            end
        end else begin
            div <= div - 8'h01;
        end
    end
endmodule // smr_shifter

// ===== verilog/smr_host.v
// Host controller that reads code words, config words and the application ID.
// Assumes the device already sits in programming mode; the host makes the link clock.
`include "smr_map.vh"
module smr_host #(
    parameter HALF = `SMR_HALF_CYC      // Core cycles per link half period
) (
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rstn,
    // User orders
    input  wire        i_go,            // One-cycle start pulse
    input  wire [1:0]  i_op,            // 0 code, 1 config, 2 app ID
    input  wire [23:0] i_addr,          // Code start address
    input  wire [7:0]  i_groups,        // Code groups of four words to read
    output reg         o_busy,          // Operation running
    output reg         o_valid,         // One-cycle pulse per readout word
    output reg  [15:0] o_data,          // Readout word
    output reg  [2:0]  o_index,         // Word index in group or config number
    output reg         o_exec_ok,       // ID showed resident executive
    output reg         o_need_load,     // ID showed executive missing
    // Pins
    output wire        o_pgc,
    output wire        o_pgd,
    output wire        o_pgd_oe,
    input  wire        i_pgd
);
    // -----------------------------------------------------------------
    // States
    // -----------------------------------------------------------------
    localparam S_IDLE = 2'b00;
    localparam S_SEND = 2'b01;          // Feeding one step of a script
    localparam S_WAIT = 2'b10;          // Waiting for shifter
    localparam OP_CODE = 2'b00;
    localparam OP_CFG  = 2'b01;
    localparam OP_ID   = 2'b10;

    reg  [1:0]  state;
    reg  [1:0]  op;                     // Latched operation
    reg  [5:0]  pc;                     // Script step
    reg  [23:0] addr;                   // Code address
    reg  [7:0]  left;                   // Groups left
    reg  [2:0]  cfg_n;                  // Config words done
    reg         start;                  // Shifter start pulse
    reg  [3:0]  code;
    reg  [23:0] word;
    wire        sh_done;
    wire [15:0] sh_data;
    reg  [3:0]  s_code;                 // Step decode results
    reg  [23:0] s_word;
    reg         s_last;                 // Last step of this script
    // Step offsets inside the fill and output parts of a code group
    wire [5:0]  fill_step = pc - 6'd7;  // Counts from the first packed read
    wire [5:0]  out_step  = pc - 6'd31; // Counts from the first copy to readout

    smr_shifter #(.HALF(HALF)) u_shift (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_start   (start),
        .i_code    (code),
        .i_word    (word),
        .o_done    (sh_done),
        .o_rdata   (sh_data),
        .o_pgc     (o_pgc),
        .o_pgd     (o_pgd),
        .o_pgd_oe  (o_pgd_oe),
        .i_pgd     (i_pgd)
    );

    // -----------------------------------------------------------------
    // Script table: each step is a code and a word; order kept exactly
    // -----------------------------------------------------------------
    // The whole sequence is hard-wired so no step can be reordered
    always @* begin
        s_code = `SMR_CODE_EXEC;
        s_word = `SMR_OP_NOP;
        s_last = 1'b0;
        case (op)
            OP_CODE: begin
                // Steps 0..2 leave reset vector; 3..6 page, pointers, write pointer
                // 7..30 packed table reads; 31..54 output; 55..56 counter reset
                if (pc < 6'd2) s_word = `SMR_OP_JUMP100;
                else if (pc == 6'd3) s_word = {12'h200, addr[23:16], 4'h0};
                else if (pc == 6'd4) s_word = `SMR_OP_W0_TBLPG;
                else if (pc == 6'd5) s_word = {4'h2, addr[15:0], 4'h6};
                else if (pc == 6'd6) s_word = `SMR_OP_CLR_WRPTR;
                // Packed fill of working regs 0..5
                else if (pc >= 6'd7 && pc <= 6'd30) begin
                    // Eight reads, each trailed by two no-ops for the pipeline
                    if ((fill_step % 6'd3) == 6'd0) begin
                        case (fill_step / 6'd3)
                            6'd0: s_word = 24'hBA1B96;
                            6'd1: s_word = 24'hBADBB6;
                            6'd2: s_word = 24'hBADBD6;
                            6'd3: s_word = 24'hBA1BB6;
                            6'd4: s_word = 24'hBA1B96;
                            6'd5: s_word = 24'hBADBB6;
                            6'd6: s_word = 24'hBADBD6;
                            default: s_word = `SMR_OP_TABLE_READ_LOW;
                        endcase
                    end
                end
                // Output regs 0..5: copy, no-op, shift out, no-op
                else if (pc >= 6'd31 && pc <= 6'd54) begin
                    if (out_step[1:0] == 2'b00)
                        s_word = `SMR_OP_W0_RDOUT | {21'h0, out_step[4:2]};
                    else if (out_step[1:0] == 2'b10) s_code = `SMR_CODE_REGISTER_SHIFT_OUT_COMMAND;
                end
                // Reset program counter after the group
                else if (pc == 6'd55) s_word = `SMR_OP_JUMP100;
                // Step 56 is the no-op that lets the jump complete
                else if (pc == 6'd57) s_last = 1'b1;
            end
            OP_CFG: begin
                // Leave reset vector with two jumps and a no-op
                if (pc < 6'd2) s_word = `SMR_OP_JUMP100;
                // Page 0xF8 via reg 0, clear both pointers
                else if (pc == 6'd3) s_word = `SMR_OP_PAGE_W0;
                else if (pc == 6'd4) s_word = `SMR_OP_W0_TBLPG;
                else if (pc == 6'd5) s_word = `SMR_OP_CLR_RDPTR;
                else if (pc == 6'd6) s_word = `SMR_OP_CLR_WRPTR;
                // Per word: read, two no-ops, copy, no-op
                else if (pc == 6'd7) s_word = `SMR_OP_TABLE_READ_LOW;
                else if (pc == 6'd10) s_word = `SMR_OP_W0_RDOUT;
                else if (pc == 6'd12) s_code = `SMR_CODE_REGISTER_SHIFT_OUT_COMMAND;
                else if (pc == 6'd14) s_word = `SMR_OP_JUMP100;
                // Step 15 is the no-op after the jump
                else if (pc == 6'd16) s_last = 1'b1;
            end
            default: begin
                // Move the ID word into readout, then shift out
                if (pc < 6'd2) s_word = `SMR_OP_JUMP100;
                else if (pc == 6'd3) s_word = `SMR_OP_ID_PAGE;
                else if (pc == 6'd4) s_word = `SMR_OP_W0_TBLPG;
                else if (pc == 6'd5) s_word = `SMR_OP_ID_ADDR;
                else if (pc == 6'd6) s_word = `SMR_OP_ID_DEST;
                else if (pc == 6'd7) s_word = `SMR_OP_ID_TBLRD;
                else if (pc == 6'd10) s_code = `SMR_CODE_REGISTER_SHIFT_OUT_COMMAND;
                // Step 11 is the trailing no-op after the shift out
                else if (pc == 6'd12) s_last = 1'b1;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        start   <= 1'b0;
        o_valid <= 1'b0;
        if (!i_rstn) begin
            // Every output low while reset is held
            state       <= S_IDLE;
            op          <= OP_CODE;
            pc          <= 6'd0;
            addr        <= 24'h000000;
            left        <= 8'h00;
            cfg_n       <= 3'h0;
            code        <= 4'h0;
            word        <= 24'h000000;
            o_busy      <= 1'b0;
            o_data      <= 16'h0000;
            o_index     <= 3'h0;
            o_exec_ok   <= 1'b0;
            o_need_load <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (i_go) begin
                        // Latch the order; a start while busy never reaches here
                        op          <= i_op;
                        pc          <= 6'd0;
                        addr        <= i_addr;
                        cfg_n       <= 3'h0;
                        left        <= (i_groups == 8'h00) ? 8'h01 : i_groups;
                        o_busy      <= 1'b1;
                        o_exec_ok   <= 1'b0;
                        o_need_load <= 1'b0;
                        state <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (s_last) begin
                        if (op == OP_CODE && left != 8'h01) begin
                            // Next group of four words
                            left <= left - 8'h01;
                            addr <= addr + 24'h000008;
                            pc <= 6'd3;
                        end else if (op == OP_CFG && cfg_n != `SMR_CFG_WORDS) begin
                            // One config register per pass
                            pc <= 6'd7;
                        end else begin
                            o_busy <= 1'b0;
                            state  <= S_IDLE;
                        end
                    end else begin
                        // Hand one step to the shifter; steps never overlap
                        code  <= s_code;
                        word  <= s_word;
                        start <= 1'b1;
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (sh_done) begin
                        pc <= pc + 6'd1;
                        state <= S_SEND;
                        if (code == `SMR_CODE_REGISTER_SHIFT_OUT_COMMAND) begin
                            o_valid <= 1'b1;
                            o_data  <= sh_data; // 16 bits per readout
                            // Code words are numbered by the working reg they came from
                            if (op == OP_CODE) o_index <= out_step[4:2];
                            else o_index <= cfg_n;
                            if (op == OP_CFG) cfg_n <= cfg_n + 3'h1;
                            if (op == OP_ID) begin
                                // Classify executive presence
                                o_exec_ok   <= (sh_data[7:0] == `SMR_ID_RESIDENT);
                                o_need_load <= (sh_data[7:0] != `SMR_ID_RESIDENT);
                            end
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // smr_host

// ===== verif/smr_host_props.sv
// Port checker for the readout host controller.
// Assumes a bind onto smr_host and a single clock domain.
module smr_host_props #(
    parameter HALF = 4                  // Core cycles per link half period
) (
    input wire        i_ref_clk,
    input wire        i_rstn,
    input wire        i_go,
    input wire        o_busy,
    input wire        o_valid,
    input wire [15:0] o_data,
    input wire        o_exec_ok,
    input wire        o_need_load,
    input wire        o_pgc,
    input wire        o_pgd,
    input wire        o_pgd_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    reg [7:0] hi_cnt;                   // Cycles the link clock has stood high
    // ---------------------------------------------
    // Helper: high phase length of the link clock
    // ---------------------------------------------
    always @(posedge i_ref_clk) begin
        hi_cnt <= (!i_rstn || !o_pgc) ? 8'h00 : hi_cnt + 8'h01;
    end
    sequence s_take;
        i_go && !o_busy;
    endsequence
    sequence s_clk_fall;
        $fell(o_pgc);
    endsequence
    a_go_busy: assert property (s_take |=> o_busy)
        else $error("start not taken");
    a_go_clears: assert property (s_take |=> !o_exec_ok && !o_need_load)
        else $error("flags kept over a start");
    a_valid_busy: assert property (o_valid |-> o_busy)
        else $error("word while idle");
    a_valid_pulse: assert property (o_valid |=> !o_valid)
        else $error("word pulse too long");
    a_data_hold: assert property ($changed(o_data) |-> o_valid)
        else $error("word changed without pulse");
    a_flags_excl: assert property (!(o_exec_ok && o_need_load))
        else $error("both id flags set");
    a_clk_high: assert property (s_clk_fall |-> hi_cnt == HALF)
        else $error("link clock high phase wrong");
    a_pgd_stable: assert property (o_pgc && $past(o_pgc) && o_pgd_oe |-> $stable(o_pgd))
        else $error("data moved while clock high");
endmodule // smr_host_props

bind smr_host smr_host_props #(.HALF(HALF)) i_props (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_go(i_go), .o_busy(o_busy), .o_valid(o_valid), .o_data(o_data), .o_exec_ok(o_exec_ok),
    .o_need_load(o_need_load), .o_pgc(o_pgc), .o_pgd(o_pgd), .o_pgd_oe(o_pgd_oe));

// ===== verif/smr_dev_model.sv
// Device model: decodes link steps and shifts out its readout register.
// Assumes the host makes the link clock and samples data on its rising edge.
module smr_dev_model (
    input  wire  i_pgc,                 // Link clock from host
    input  wire  i_pgd,                 // Resolved data line
    output logic o_pgd                  // Device data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [27:0] trace[$];              // Every step as code and word
    logic [15:0] sent[$];               // Every word shifted out
    logic [15:0] cfg[0:6];              // Configuration words
    logic [15:0] wr[0:15];              // Working registers
    logic [15:0] app_id = 16'h00BB;     // Set by the bench per pass
    logic [15:0] rdout = 16'h0000;      // Readout register
    logic [7:0]  page = 8'h00;          // Table page register
    logic [27:0] sh = 28'h0000000;      // Incoming bits
    int          cnt = 0;
    int          left = 0;
    int          rdp = 0;
    int          k = 0;
    initial begin
        o_pgd = 1'b0;
        foreach (cfg[i]) cfg[i] = 16'($urandom);
    end
    // Instruction effects, only those the readout paths need
    task automatic exec(input logic [23:0] w);
        if (w[23:20] == 4'h2) wr[w[3:0]] = w[19:4];
        else if (w == 24'h880190) page = wr[0][7:0];
        else if (w == 24'hEB0300) rdp = 0;
        else if (w == 24'hEB0380) k = 0;
        else if (w[23:4] == 20'h883C2) rdout = wr[w[3:0]];
        else if (w == 24'hBA0890 && wr[1] == 16'h0784)
            rdout = (page == 8'h80 && wr[0] == 16'h05BE) ? app_id : 16'h0000;
        else if (w == 24'hBA0BB6 && page == 8'hF8) begin
            wr[k] = cfg[rdp / 2];
            rdp = rdp + 2;
        end else if (w[23:16] == 8'hBA) begin
            wr[k] = 16'($urandom);
            k = (k + 1) % 6;
        end
    endtask
    // Receive code then word, both LSB first
    always @(posedge i_pgc) begin
        if (left > 0) begin
            left = left - 1;
            if (left == 0) cnt = 0;
        end else begin
            sh[cnt] = i_pgd;
            cnt = cnt + 1;
            if (cnt == 4 && sh[3:0] == 4'h1) begin
                left = 16;
                trace.push_back(28'h1000000);
                sent.push_back(rdout);
            end else if (cnt == 28) begin
                trace.push_back({sh[3:0], sh[27:4]});
                exec(sh[27:4]);
                cnt = 0;
            end
        end
    end
    // Released line toggles so a stale bit is never read as good
    always @(negedge i_pgc) begin
        o_pgd <= (left > 0) ? rdout[left - 1] : ~o_pgd;
    end
endmodule // smr_dev_model

// ===== verif/smr_host_bench.sv
// Bench for smr_host against the device model.
// Assumes smr_dev_model and the bound port checker.
module smr_host_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        go = 1'b0;
    logic [1:0]  op = 2'h0;
    logic [23:0] addr = 24'h000000;
    logic [7:0]  groups = 8'h00;
    wire         busy, valid, exec_ok, need_load, pgc, pgd_h, pgd_oe, pgd_d;
    wire  [15:0] data;
    wire  [2:0]  index;
    wire         pgd_line = pgd_oe ? pgd_h : pgd_d;
    int          n_fail = 0;
    int          tests_run = 0;
    logic [27:0] exp_q[$];
    always #5 clk = ~clk;
    smr_host #(.HALF(4)) i_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_go(go), .i_op(op),
        .i_addr(addr), .i_groups(groups), .o_busy(busy), .o_valid(valid), .o_data(data),
        .o_index(index), .o_exec_ok(exec_ok), .o_need_load(need_load), .o_pgc(pgc),
        .o_pgd(pgd_h), .o_pgd_oe(pgd_oe), .i_pgd(pgd_line));
    smr_dev_model i_dev (.i_pgc(pgc), .i_pgd(pgd_line), .o_pgd(pgd_d));
    task automatic chk_val(string name, logic [27:0] e, logic [27:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk_flag(string name, logic e, logic g);
        chk_val(name, {27'h0, e}, {27'h0, g});
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp_trace();
        chk_val("steps", exp_q.size(), i_dev.trace.size());
        foreach (exp_q[i]) chk_val("step", exp_q[i], i_dev.trace[i]);
    endtask
    // One operation; a second start while busy must be ignored
    task automatic run(input logic [1:0] o, output int n);
        int t;
        n = 0;
        i_dev.trace.delete();
        i_dev.sent.delete();
        @(posedge clk);
        op <= o;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        op <= 2'h3 - o;
        repeat (20) @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (t = 0; t < 40000 && busy === 1'b1; t++) begin
            @(posedge clk);
            #1;
            if (valid === 1'b1) begin
                chk_val("data", i_dev.sent.pop_front(), data);
                chk_val("index", (o == 2'h0) ? n % 6 : n, index);
                if (o == 2'h1) chk_val("cfg", i_dev.cfg[n], data);
                n++;
            end
        end
        chk_flag("busy", 1'b0, busy);
    endtask
    initial begin
        #900000;
        n_fail++;
        finish_test();
    end
    initial begin
        int n;
        int g;
        int m;
        void'($urandom(82));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk_flag("idle", 1'b0, busy | valid | pgc);
        exp_q = {28'h0040100, 28'h0040100, 28'h0, 28'h0200F80, 28'h0880190, 28'h0EB0300,
                 28'h0EB0380};
        repeat (7) exp_q = {exp_q, 28'h0BA0BB6, 28'h0, 28'h0, 28'h0883C20, 28'h0, 28'h1000000,
                            28'h0, 28'h0040100, 28'h0};
        run(2'h1, n);
        chk_val("cfg words", 7, n);
        cmp_trace();
        for (g = 0; g < 2; g++) begin
            i_dev.app_id = {8'($urandom), (g == 0) ? 8'hBB : 8'($urandom_range(0, 186))};
            exp_q = {28'h0040100, 28'h0040100, 28'h0, 28'h0200800, 28'h0880190, 28'h0205BE0,
                     28'h0207841, 28'h0BA0890, 28'h0, 28'h0, 28'h1000000, 28'h0};
            run(2'h2, n);
            cmp_trace();
            chk_flag("exec ok", g == 0, exec_ok);
            chk_flag("need load", g != 0, need_load);
        end
        for (g = 0; g < 2; g++) begin
            @(posedge clk);
            groups <= 8'(2 * g);
            addr <= {8'($urandom_range(0, 247)), 15'($urandom), 1'b0};
            run(2'h0, n);
            chk_val("code words", (g == 0) ? 6 : 12, n);
            chk_val("page", {16'h0200, addr[23:16], 4'h0}, i_dev.trace[3]);
            chk_val("fill", 28'h0BA0BB6, i_dev.trace[28]);
            m = 0;
            foreach (i_dev.trace[p]) if (i_dev.trace[p] === 28'h1000000 && p > 1) begin
                chk_val("copy", {24'h0883C2, 4'(m % 6)}, i_dev.trace[p - 2]);
                chk_val("nop", 28'h0, i_dev.trace[p - 1] | i_dev.trace[p + 1]);
                if (m % 6 == 5) chk_val("jump", 28'h0040100, i_dev.trace[p + 2]);
                m++;
            end
        end
        finish_test();
    end
endmodule // smr_host_bench
